// ===== pkg/pfg_defs.svh
// register map, field positions and reset values of the pwm fault/generator
`ifndef PFG_DEFS_SVH
`define PFG_DEFS_SVH
// -----------------------------------------------------------------------------
// offsets
// -----------------------------------------------------------------------------
`define PFG_OFF_FAULT_CFG 8'h68
`define PFG_OFF_FAULT_FRC 8'h6c
`define PFG_OFF_FAULT_STS 8'h70
`define PFG_OFF_STAMP_CFG 8'h74
`define PFG_OFF_STAMP_A   8'h78
`define PFG_OFF_STAMP_B   8'h7c
`define PFG_OFF_EVT_CFG   8'h80
`define PFG_OFF_SW_FORCE  8'h84
`define PFG_OFF_ACT_A     8'h88
`define PFG_OFF_ACT_B     8'h8c
// -----------------------------------------------------------------------------
// fields and masks
// -----------------------------------------------------------------------------
`define PFG_FC_CBC_EN   0
`define PFG_FC_SW_CBC   3
`define PFG_FC_OST_EN   4
`define PFG_FC_SW_OST   7
`define PFG_FC_ACT_A    8
`define PFG_FC_ACT_B    16
`define PFG_FF_CBC_TRIG 0
`define PFG_FF_REFRESH  1
`define PFG_FF_OST_TRIG 3
`define PFG_FF_OST_CLR  4
`define PFG_SC_METH_B   4
`define PFG_EC_T0_SEL   4
`define PFG_EC_T1_SEL   7
`define PFG_SW_MODE_A   6
`define PFG_SW_MODE_B   8
`define PFG_SW_SGL_A    10
`define PFG_SW_SGL_B    13
`define PFG_SEL_SYNC    3'h3
`define PFG_MSK_FAULT_CFG 32'h00ff_ffff
`define PFG_MSK_FAULT_FRC 32'h0000_001f
`define PFG_MSK_STAMP_CFG 32'h0000_00ff
`define PFG_MSK_EVT_CFG   32'h0000_03ff
`define PFG_MSK_SW_FORCE  32'h0000_ffff
`define PFG_MSK_ACT       32'h00ff_ffff
`define PFG_RST_WORD      32'h0000_0000
`endif

// ===== pkg/pfg_pkg.sv
// types shared by the pwm fault/generator block
package pfg_pkg;
    typedef enum logic [1:0] {
        PFG_ACT_NONE   = 2'h0,
        PFG_ACT_LOW    = 2'h1,
        PFG_ACT_HIGH   = 2'h2,
        PFG_ACT_TOGGLE = 2'h3
    } pfg_act_e;
endpackage

// ===== rtl/pfg_top.sv
// pwm operator fault handler and generator 1 with wishbone registers
//
// Design decision made here: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "pfg_defs.svh"
module pfg_top #(
    parameter int TS_W = 16
) (
    // clock and reset
    input  wire logic            clk_i,
    input  wire logic            rst_i,
    // wishbone slave
    input  wire logic            wb_cyc_i,
    input  wire logic            wb_stb_i,
    input  wire logic            wb_we_i,
    input  wire logic [7:0]      wb_adr_i,
    input  wire logic [3:0]      wb_sel_i,
    input  wire logic [31:0]     wb_dat_i,
    output logic      [31:0]     wb_dat_o,
    output logic                 wb_ack_o,
    // timer and event inputs
    input  wire logic            timer_dir_i,
    input  wire logic [TS_W-1:0] timer_cnt_i,
    input  wire logic            timer_zero_event_i,
    input  wire logic            timer_period_event_i,
    input  wire logic            sync_taken_i,
    input  wire logic            fault_in0_i,
    input  wire logic            fault_in1_i,
    input  wire logic            fault_in2_i,
    // power stage
    output logic                 op1_out_a_o,
    output logic                 op1_out_b_o
);
    // -------------------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------------------
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic apply(input logic [1:0] a, input logic cur);
        case (pfg_pkg::pfg_act_e'(a))
            pfg_pkg::PFG_ACT_LOW:    return 1'b0;
            pfg_pkg::PFG_ACT_HIGH:   return 1'b1;
            pfg_pkg::PFG_ACT_TOGGLE: return ~cur;
            default:                 return cur;
        endcase
    endfunction

    // four-bit transfer method: zero means every cycle, bit3 blocks
    function automatic logic upd4(input logic [3:0] m, input logic z,
                                  input logic p, input logic s);
        return (m == 4'h0) ||
               (!m[3] && ((m[0] && z) || (m[1] && p) || (m[2] && s)));
    endfunction

    // -------------------------------------------------------------------------
    // wishbone slave
    // -------------------------------------------------------------------------
    logic        ack_ff;
    logic [31:0] dat_ff;
    logic        req;
    logic        wr;
    assign req = wb_cyc_i && wb_stb_i && !ack_ff;
    assign wr  = req && wb_we_i;
    assign wb_ack_o = ack_ff;
    assign wb_dat_o = dat_ff;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= req;
        end
    end

    logic [31:0]     fcfg_ff;
    logic [31:0]     ffrc_ff;
    logic [31:0]     scfg_ff;
    logic [31:0]     evcfg_ff;
    logic [31:0]     swf_ff;
    logic [31:0]     acta_sh_ff;
    logic [31:0]     actb_sh_ff;
    logic [TS_W-1:0] sha_ff;
    logic [TS_W-1:0] shb_ff;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fcfg_ff    <= `PFG_RST_WORD;
            ffrc_ff    <= `PFG_RST_WORD;
            scfg_ff    <= `PFG_RST_WORD;
            evcfg_ff   <= `PFG_RST_WORD;
            swf_ff     <= `PFG_RST_WORD;
            acta_sh_ff <= `PFG_RST_WORD;
            actb_sh_ff <= `PFG_RST_WORD;
        end else if (wr) begin
            case (wb_adr_i)
                `PFG_OFF_FAULT_CFG: fcfg_ff <= merge(fcfg_ff, wb_dat_i,
                    wb_sel_i) & `PFG_MSK_FAULT_CFG;
                `PFG_OFF_FAULT_FRC: ffrc_ff <= merge(ffrc_ff, wb_dat_i,
                    wb_sel_i) & `PFG_MSK_FAULT_FRC;
                `PFG_OFF_STAMP_CFG: scfg_ff <= merge(scfg_ff, wb_dat_i,
                    wb_sel_i) & `PFG_MSK_STAMP_CFG;
                `PFG_OFF_EVT_CFG: evcfg_ff <= merge(evcfg_ff, wb_dat_i,
                    wb_sel_i) & `PFG_MSK_EVT_CFG;
                `PFG_OFF_SW_FORCE: swf_ff <= merge(swf_ff, wb_dat_i,
                    wb_sel_i) & `PFG_MSK_SW_FORCE;
                `PFG_OFF_ACT_A: acta_sh_ff <= merge(acta_sh_ff, wb_dat_i,
                    wb_sel_i) & `PFG_MSK_ACT;
                `PFG_OFF_ACT_B: actb_sh_ff <= merge(actb_sh_ff, wb_dat_i,
                    wb_sel_i) & `PFG_MSK_ACT;
                default: ;
            endcase
        end
    end

    // stamp shadows take software writes only
    logic wr_sa;
    logic wr_sb;
    assign wr_sa = wr && (wb_adr_i == `PFG_OFF_STAMP_A);
    assign wr_sb = wr && (wb_adr_i == `PFG_OFF_STAMP_B);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sha_ff <= '0;
            shb_ff <= '0;
        end else begin
            if (wr_sa) begin
                sha_ff <= TS_W'(merge(32'(sha_ff), wb_dat_i, wb_sel_i));
            end
            if (wr_sb) begin
                shb_ff <= TS_W'(merge(32'(shb_ff), wb_dat_i, wb_sel_i));
            end
        end
    end

    // -------------------------------------------------------------------------
    // events
    // -------------------------------------------------------------------------
    logic [TS_W-1:0] sta_ff;
    logic [TS_W-1:0] stb_ff;
    logic            timer_zero_event;
    logic            timer_period_event;
    logic            stamp_a_match_event;
    logic            stamp_b_match_event;
    logic            t0;
    logic            t1;
    logic [2:0]      fin;
    assign timer_zero_event = timer_zero_event_i;
    assign timer_period_event = timer_period_event_i;
    assign stamp_a_match_event = (timer_cnt_i == sta_ff);
    assign stamp_b_match_event = (timer_cnt_i == stb_ff);
    assign fin = {fault_in2_i, fault_in1_i, fault_in0_i};

    // selector change acts at once, no shadow
    function automatic logic pick(input logic [2:0] s, input logic [2:0] f,
                                  input logic sy);
        if (s < `PFG_SEL_SYNC) begin
            return f[s[1:0]];
        end
        return (s == `PFG_SEL_SYNC) ? sy : 1'b0;
    endfunction
    assign t0 = pick(evcfg_ff[`PFG_EC_T0_SEL +: 3], fin, sync_taken_i);
    assign t1 = pick(evcfg_ff[`PFG_EC_T1_SEL +: 3], fin, sync_taken_i);

    // -------------------------------------------------------------------------
    // stamp shadow to active
    // -------------------------------------------------------------------------
    logic upa;
    logic upb;
    logic pend_a_ff;
    logic pend_b_ff;
    assign upa = upd4(scfg_ff[3:0], timer_zero_event, timer_period_event, sync_taken_i);
    assign upb = upd4(scfg_ff[`PFG_SC_METH_B +: 4], timer_zero_event, timer_period_event,
                      sync_taken_i);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sta_ff    <= '0;
            stb_ff    <= '0;
            pend_a_ff <= 1'b0;
            pend_b_ff <= 1'b0;
        end else begin
            if (upa) begin
                sta_ff <= sha_ff;
            end
            if (upb) begin
                stb_ff <= shb_ff;
            end
            // a write in the transfer cycle keeps the flag
            pend_a_ff <= wr_sa || (pend_a_ff && !upa);
            pend_b_ff <= wr_sb || (pend_b_ff && !upb);
        end
    end

    // -------------------------------------------------------------------------
    // generator configuration and hold force activation
    // -------------------------------------------------------------------------
    logic [23:0] acta_ff;
    logic [23:0] actb_ff;
    logic [3:0]  hold_ff;
    logic [5:0]  hm;
    logic        hup;
    assign hm  = swf_ff[5:0];
    // six-bit method, bit5 blocks
    assign hup = (hm == 6'h00) || (!hm[5] && ((hm[0] && timer_zero_event) ||
                 (hm[1] && timer_period_event) || (hm[2] && stamp_a_match_event) || (hm[3] && stamp_b_match_event) ||
                 (hm[4] && sync_taken_i)));
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            acta_ff <= '0;
            actb_ff <= '0;
            hold_ff <= '0;
        end else begin
            if (upd4(evcfg_ff[3:0], timer_zero_event, timer_period_event, sync_taken_i)) begin
                acta_ff <= acta_sh_ff[23:0];
                actb_ff <= actb_sh_ff[23:0];
            end
            if (hup) begin
                hold_ff <= swf_ff[`PFG_SW_MODE_A +: 4];
            end
        end
    end

    // -------------------------------------------------------------------------
    // toggle triggers
    // -------------------------------------------------------------------------
    logic [4:0] trig;
    logic [4:0] prev_ff;
    logic [4:0] flip;
    assign trig = {swf_ff[`PFG_SW_SGL_B], swf_ff[`PFG_SW_SGL_A],
                   ffrc_ff[`PFG_FF_OST_CLR], ffrc_ff[`PFG_FF_OST_TRIG],
                   ffrc_ff[`PFG_FF_CBC_TRIG]};
    // either edge counts, the level itself does nothing
    assign flip = trig ^ prev_ff;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev_ff <= '0;
        end else begin
            prev_ff <= trig;
        end
    end

    // -------------------------------------------------------------------------
    // fault handler
    // -------------------------------------------------------------------------
    logic ost_trip;
    logic cbc_trip;
    logic refresh;
    logic ost_on_ff;
    logic cbc_on_ff;
    assign ost_trip = |(fin & fcfg_ff[`PFG_FC_OST_EN +: 3]) ||
        (flip[1] && fcfg_ff[`PFG_FC_SW_OST]);
    assign cbc_trip = |(fin & fcfg_ff[`PFG_FC_CBC_EN +: 3]) ||
        (flip[0] && fcfg_ff[`PFG_FC_SW_CBC]);
    assign refresh = (ffrc_ff[`PFG_FF_REFRESH] && timer_zero_event) ||
                     (ffrc_ff[`PFG_FF_REFRESH + 1] && timer_period_event);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ost_on_ff <= 1'b0;
            cbc_on_ff <= 1'b0;
        end else begin
            // new trip wins over a clear in the same cycle
            ost_on_ff <= ost_trip || (ost_on_ff && !flip[2]);
            cbc_on_ff <= cbc_trip || (cbc_on_ff && !refresh);
        end
    end

    // -------------------------------------------------------------------------
    // generator state and outputs
    // -------------------------------------------------------------------------
    logic [5:0] evs;
    logic       gen_a_ff;
    logic       gen_b_ff;
    logic       out_a_ff;
    logic       out_b_ff;
    assign evs = {t1, t0, stamp_b_match_event, stamp_a_match_event, timer_period_event, timer_zero_event};
    assign op1_out_a_o = out_a_ff;
    assign op1_out_b_o = out_b_ff;

    // later events in the list win when several fire together
    function automatic logic step(input logic [23:0] act, input logic cur,
                                  input logic dn, input logic [5:0] e,
                                  input logic sflip, input logic [1:0] smode);
        logic v;
        v = cur;
        for (int i = 0; i < 6; i++) begin
            if (e[i]) begin
                v = apply(act[(dn ? 12 : 0) + 2*i +: 2], v);
            end
        end
        // single force beats events; modes 0 and 3 never toggle
        if (sflip && (smode != 2'h3)) begin
            v = apply(smode, v);
        end
        return v;
    endfunction

    function automatic logic drive(input logic [7:0] fa, input logic one_shot_trip,
                                   input logic cbc, input logic dn,
                                   input logic [1:0] hold, input logic g);
        logic [1:0] a;
        a = one_shot_trip ? fa[(dn ? 4 : 6) +: 2] : cbc ? fa[(dn ? 0 : 2) +: 2] : 2'h0;
        if (a != 2'h0) begin
            return apply(a, g);
        end
        if (hold == 2'h1 || hold == 2'h2) begin
            return hold[1];
        end
        return g;
    endfunction

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gen_a_ff <= 1'b0;
            gen_b_ff <= 1'b0;
        end else begin
            gen_a_ff <= step(acta_ff, gen_a_ff, !timer_dir_i, evs, flip[3],
                             swf_ff[`PFG_SW_SGL_A + 1 +: 2]);
            gen_b_ff <= step(actb_ff, gen_b_ff, !timer_dir_i, evs, flip[4],
                             swf_ff[`PFG_SW_SGL_B + 1 +: 2]);
        end
    end

    // overrides leave the generator state running underneath
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_a_ff <= 1'b0;
            out_b_ff <= 1'b0;
        end else begin
            out_a_ff <= drive(fcfg_ff[`PFG_FC_ACT_A +: 8], ost_on_ff,
                              cbc_on_ff, !timer_dir_i, hold_ff[1:0], gen_a_ff);
            out_b_ff <= drive(fcfg_ff[`PFG_FC_ACT_B +: 8], ost_on_ff,
                              cbc_on_ff, !timer_dir_i, hold_ff[3:2], gen_b_ff);
        end
    end

    // -------------------------------------------------------------------------
    // read mux
    // -------------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_ff <= '0;
        end else if (req && !wb_we_i) begin
            case (wb_adr_i)
                `PFG_OFF_FAULT_CFG: dat_ff <= fcfg_ff;
                `PFG_OFF_FAULT_FRC: dat_ff <= ffrc_ff;
                `PFG_OFF_FAULT_STS: dat_ff <= {30'h0, ost_on_ff, cbc_on_ff};
                `PFG_OFF_STAMP_CFG: dat_ff <= {22'h0, pend_b_ff, pend_a_ff,
                                               scfg_ff[7:0]};
                `PFG_OFF_STAMP_A:   dat_ff <= 32'(sha_ff);
                `PFG_OFF_STAMP_B:   dat_ff <= 32'(shb_ff);
                `PFG_OFF_EVT_CFG:   dat_ff <= evcfg_ff;
                `PFG_OFF_SW_FORCE:  dat_ff <= swf_ff;
                `PFG_OFF_ACT_A:     dat_ff <= acta_sh_ff;
                `PFG_OFF_ACT_B:     dat_ff <= actb_sh_ff;
                default:            dat_ff <= '0;
            endcase
        end
    end

    // -------------------------------------------------------------------------
    // checks
    // -------------------------------------------------------------------------
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_ost_fault;
        (fault_in0_i && fcfg_ff[`PFG_FC_OST_EN]) |=> ost_on_ff;
    endproperty
    a_ost_fault: assert property (p_ost_fault)
        else $error("enabled fault 0 did not start one-shot");

    property p_cbc_fault;
        (fault_in2_i && fcfg_ff[`PFG_FC_CBC_EN + 2]) |=> cbc_on_ff;
    endproperty
    a_cbc_fault: assert property (p_cbc_fault)
        else $error("enabled fault 2 did not start cycle action");

    property p_ost_sw_off;
        (!ost_on_ff && !fcfg_ff[`PFG_FC_SW_OST] && fin == 3'h0) |=> !ost_on_ff;
    endproperty
    a_ost_sw_off: assert property (p_ost_sw_off)
        else $error("one-shot started with nothing enabled");

    property p_ost_flip;
        ($changed(ffrc_ff[`PFG_FF_OST_TRIG]) && fcfg_ff[`PFG_FC_SW_OST])
            |=> ost_on_ff;
    endproperty
    a_ost_flip: assert property (p_ost_flip)
        else $error("software one-shot flip ignored");

    property p_ost_clear;
        (ost_on_ff && flip[2] && !ost_trip) |=> !ost_on_ff;
    endproperty
    a_ost_clear: assert property (p_ost_clear)
        else $error("one-shot not cleared by clear flip");

    property p_cbc_hold;
        (cbc_on_ff && !refresh) |=> cbc_on_ff;
    endproperty
    a_cbc_hold: assert property (p_cbc_hold)
        else $error("cycle action ended without refresh");

    property p_stamp_block;
        (scfg_ff[3] && wr_sa) |=> $stable(sta_ff) ##1 pend_a_ff;
    endproperty
    a_stamp_block: assert property (p_stamp_block)
        else $error("blocked stamp a reached active register");

    property p_pend;
        wr_sb |=> pend_b_ff;
    endproperty
    a_pend: assert property (p_pend)
        else $error("stamp b pending flag not set");

    property p_hold_low;
        (hold_ff[1:0] == 2'h1 && !ost_on_ff && !cbc_on_ff) |=> !out_a_ff;
    endproperty
    a_hold_low: assert property (p_hold_low)
        else $error("hold low did not drive output a low");
endmodule
`default_nettype wire

// ===== verif/pfg_gate_drv.sv
// gate driver model standing on the power-stage side of the generator pins
`timescale 1ns/1ps
`default_nettype none
module pfg_gate_drv (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // gate commands in, switch state out
    input  wire logic gate_a_i,
    input  wire logic gate_b_i,
    output logic      sw_a_o,
    output logic      sw_b_o
);
    // switches lag one cycle, so checks must settle first
    always_ff @(posedge clk_i) begin
        sw_a_o <= rst_i ? 1'b0 : gate_a_i;
        sw_b_o <= rst_i ? 1'b0 : gate_b_i;
    end
endmodule
`default_nettype wire

// ===== verif/pfg_top_tb.sv
// self-checking bench for the pwm fault handler and generator
`timescale 1ns/1ps
`default_nettype none
`include "pfg_defs.svh"
module pfg_top_tb;
    logic        clk_i, rst_i, cyc, stb, we, dir, zev, pev, syn, ack;
    logic        oa, ob, sa, sb;
    logic [2:0]  flt;
    logic [7:0]  adr;
    logic [15:0] cnt;
    logic [31:0] dat, dout, q, rnd, frc;
    int          err_total, tests_run, cycles, i;
    pfg_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
        .wb_dat_i(dat), .wb_dat_o(dout), .wb_ack_o(ack),
        .timer_dir_i(dir), .timer_cnt_i(cnt), .timer_zero_event_i(zev),
        .timer_period_event_i(pev), .sync_taken_i(syn),
        .fault_in0_i(flt[0]), .fault_in1_i(flt[1]), .fault_in2_i(flt[2]),
        .op1_out_a_o(oa), .op1_out_b_o(ob));
    pfg_gate_drv drv (.clk_i(clk_i), .rst_i(rst_i), .gate_a_i(oa),
        .gate_b_i(ob), .sw_a_o(sa), .sw_b_o(sb));
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // hang guard, well above the length of the sequence
    always @(posedge clk_i) begin
        cycles++;
        if (cycles > 20000) begin
            err_total++;
            finish_test();
        end
    end
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= d;
        @(posedge clk_i);
        while (ack !== 1'b1) @(posedge clk_i);
        q = dout;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic chk(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0000_0000);
        tests_run++;
        if (q !== e) begin
            err_total++;
            $display("MISMATCH reg %h exp %h got %h", a, e, q);
        end
    endtask
    task automatic chk1(input string n, input logic e, input logic g);
        tests_run++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s exp %b got %b", n, e, g);
        end
    endtask
    // trip flips need two edges, outputs one more: settle after writes
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
        repeat (4) @(posedge clk_i);
    endtask
    // m: zero, period, sync, fault0..2 from bit 0 up
    task automatic pulse(input logic [5:0] m);
        @(posedge clk_i);
        {flt, syn, pev, zev} <= m;
        @(posedge clk_i);
        {flt, syn, pev, zev} <= 6'h00;
        repeat (4) @(posedge clk_i);
    endtask
    initial begin
        {cyc, stb, we, dir, zev, pev, syn, flt} = '0;
        {adr, dat, frc, err_total, tests_run, cycles} = '0;
        cnt = 16'hffff;
        rnd = 32'h0000_7615;
        rst_i = 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        for (i = 0; i < 11; i++) chk(8'h68 + 8'(4 * i), 32'h0000_0000);
        $display("test reset values done");
        for (i = 0; i < 4; i++) begin
            rnd = lfsr(rnd);
            wr(`PFG_OFF_EVT_CFG, rnd);
            chk(`PFG_OFF_EVT_CFG, rnd & `PFG_MSK_EVT_CFG);
            wr(`PFG_OFF_ACT_B, rnd);
            chk(`PFG_OFF_ACT_B, rnd & `PFG_MSK_ACT);
        end
        wr(`PFG_OFF_EVT_CFG, 32'h0000_0000);
        wr(`PFG_OFF_ACT_B, 32'h0000_0000);
        $display("test register access done");
        dir <= 1'b1;
        wr(`PFG_OFF_FAULT_CFG, 32'h0040_8010);
        pulse(6'h08);
        chk(`PFG_OFF_FAULT_STS, 32'h0000_0002);
        chk1("out_a", 1'b1, sa);
        chk1("out_b", 1'b0, sb);
        frc = frc ^ 32'h0000_0010;
        wr(`PFG_OFF_FAULT_FRC, frc);
        chk(`PFG_OFF_FAULT_STS, 32'h0000_0000);
        chk1("out_a", 1'b0, sa);
        pulse(6'h10);
        frc = frc ^ 32'h0000_0008;
        wr(`PFG_OFF_FAULT_FRC, frc);
        chk(`PFG_OFF_FAULT_STS, 32'h0000_0000);
        wr(`PFG_OFF_FAULT_CFG, 32'h0040_8090);
        frc = frc ^ 32'h0000_0008;
        wr(`PFG_OFF_FAULT_FRC, frc);
        chk(`PFG_OFF_FAULT_STS, 32'h0000_0002);
        frc = frc ^ 32'h0000_0012;
        wr(`PFG_OFF_FAULT_FRC, frc);
        wr(`PFG_OFF_FAULT_CFG, 32'h0000_000c);
        pulse(6'h20);
        chk(`PFG_OFF_FAULT_STS, 32'h0000_0001);
        pulse(6'h02);
        chk(`PFG_OFF_FAULT_STS, 32'h0000_0001);
        pulse(6'h01);
        chk(`PFG_OFF_FAULT_STS, 32'h0000_0000);
        frc = frc ^ 32'h0000_0001;
        wr(`PFG_OFF_FAULT_FRC, frc);
        chk(`PFG_OFF_FAULT_STS, 32'h0000_0001);
        pulse(6'h01);
        wr(`PFG_OFF_FAULT_CFG, 32'h0000_0000);
        $display("test fault handler done");
        rnd = lfsr(rnd);
        wr(`PFG_OFF_STAMP_CFG, 32'h0000_0008);
        wr(`PFG_OFF_ACT_A, 32'h0000_0020);
        wr(`PFG_OFF_STAMP_A, rnd);
        cnt <= rnd[15:0];
        chk(`PFG_OFF_STAMP_A, {16'h0000, rnd[15:0]});
        chk(`PFG_OFF_STAMP_CFG, 32'h0000_0108);
        chk1("out_a", 1'b0, sa);
        wr(`PFG_OFF_STAMP_CFG, 32'h0000_0000);
        chk(`PFG_OFF_STAMP_CFG, 32'h0000_0000);
        chk1("out_a", 1'b1, sa);
        wr(`PFG_OFF_STAMP_CFG, 32'h0000_0001);
        wr(`PFG_OFF_STAMP_A, ~rnd);
        chk(`PFG_OFF_STAMP_CFG, 32'h0000_0101);
        pulse(6'h01);
        chk(`PFG_OFF_STAMP_CFG, 32'h0000_0001);
        $display("test time stamps done");
        wr(`PFG_OFF_ACT_A, 32'h0000_0300);
        for (i = 0; i < 5; i++) begin
            wr(`PFG_OFF_EVT_CFG, 32'(i) << 4);
            pulse(i < 3 ? 6'h08 << i : 6'h04);
            chk1("out_a", i == 4 || i[0], sa);
        end
        $display("test extra events done");
        wr(`PFG_OFF_SW_FORCE, 32'h0000_0080);
        chk1("out_a", 1'b1, sa);
        wr(`PFG_OFF_SW_FORCE, 32'h0000_0040);
        chk1("out_a", 1'b0, sa);
        wr(`PFG_OFF_SW_FORCE, 32'h0000_0020);
        chk1("out_a", 1'b0, sa);
        wr(`PFG_OFF_SW_FORCE, 32'h0000_0000);
        chk1("out_a", 1'b1, sa);
        wr(`PFG_OFF_SW_FORCE, 32'h0000_0c00);
        chk1("out_a", 1'b0, sa);
        wr(`PFG_OFF_SW_FORCE, 32'h0000_1000);
        chk1("out_a", 1'b1, sa);
        wr(`PFG_OFF_SW_FORCE, 32'h0000_1c00);
        chk1("out_a", 1'b1, sa);
        $display("test software force done");
        finish_test();
    end
endmodule
`default_nettype wire
